// [hw/rbv_defs.svh]
`ifndef RBV_DEFS_SVH
`define RBV_DEFS_SVH
`define RBV_SRC_COUNT      9
`define RBV_SRC_POR        0
`define RBV_SRC_PIN        1
`define RBV_SRC_CMP        2
`define RBV_SRC_SW         3
`define RBV_SRC_SUPPLY     4
`define RBV_SRC_WDOG       5
`define RBV_SRC_MISCLK     6
`define RBV_SRC_FLASH      7
`define RBV_SRC_USB        8
`define RBV_BOOT_SIG       8'hA5
`define RBV_RESET_VECTOR   16'h0000
`define RBV_PORT_WIDTH     8
`define RBV_PORT_RESET     8'hFF
`define RBV_CLKSEL_RESET   2'h0
`define RBV_REL_NS         16
`define RBV_CLK_NS         4
`define RBV_REL_CYCLES     ((`RBV_REL_NS + `RBV_CLK_NS - 1) / `RBV_CLK_NS)
`endif

// [hw/rbv_pkg.sv]
package rbv_pkg;
	typedef enum logic [1:0] {
		RBV_RUN,
		RBV_HOLD,
		RBV_RELEASE
	} rbv_state_type;
	typedef logic [8:0] rbv_src_type;
endpackage

// [hw/rbv_sync.sv]
// two-flop synchroniser for asynchronous request levels
module rbv_sync (
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire rbv_pkg::rbv_src_type async_in,
	output rbv_pkg::rbv_src_type      sync_out
);
	import rbv_pkg::*;
	typedef struct packed {
		logic [8:0] stage1;
		logic [8:0] stage2;
	} rbv_sync_st_type;
	rbv_sync_st_type st;
	rbv_sync_st_type next_st;

	// stage1 only feeds stage2, so metastability never reaches logic
	always_comb begin
		next_st.stage1 = async_in;
		next_st.stage2 = st.stage1;
	end

	// resets to "all requesting" so the block starts held in reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= '{stage1: 9'h1_FF, stage2: 9'h1_FF};
		end else begin
			st <= next_st;
		end
	end

	assign sync_out = st.stage2;
endmodule

// [hw/rbv_ctrl.sv]
// How it works
// - halt the core while in reset
// - load defaults except power-on-only bits
// - disable interrupts and timers in reset
// - leave data memory untouched
// - port latches one, drivers open-drain
// - weak pull-ups enabled always
// - drive reset pin low for supply resets
// - load PC with the start vector, select internal oscillator on exit
// - enable watchdog; default start at zero
// - nine request sources enter reset
// - signature 0xA5 means bootloader present
// - bootloader present: start at bootloader vector
// - no bootloader: start at zero
`include "rbv_defs.svh"
module rbv_ctrl (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              por_req,
	input  wire logic              external_reset_pin_n_in,
	input  wire logic              cmp_req,
	input  wire logic              sw_req,
	input  wire logic              supply_req,
	input  wire logic              wdog_req,
	input  wire logic              misclk_req,
	input  wire logic              flash_err_req,
	input  wire logic              usb_req,
	input  wire logic        [7:0] boot_sig_byte,
	input  wire logic       [15:0] boot_vector,
	output logic                   core_halt,
	output logic                   reg_reset,
	output logic                   por_reg_reset,
	output logic                   irq_timer_disable,
	output logic                   ram_reset,
	output logic             [7:0] port_latch_set,
	output logic             [7:0] port_open_drain,
	output logic             [7:0] port_pullup_en,
	output logic                   external_reset_pin_n_out,
	output logic                   external_reset_pin_n_oe,
	output logic                   pc_load,
	output logic            [15:0] pc_value,
	output logic             [1:0] clk_select,
	output logic                   wdog_enable,
	output logic                   boot_present,
	output rbv_pkg::rbv_src_type   reset_cause
);
	import rbv_pkg::*;

	typedef struct packed {
		rbv_state_type state;
		logic [2:0]    rel_cnt;
		logic          drive_pin;
		logic          por_seen;
		logic [8:0]    cause;
		logic          pc_load;
		logic [15:0]   pc_value;
		logic [1:0]    clk_select;
		logic          wdog_enable;
		logic          boot_present;
	} rbv_st_type;

	rbv_st_type st;
	rbv_st_type next_st;
	logic [8:0] raw_req;
	logic [8:0] req;

	// true when the signature byte marks a bootloader image
	function automatic logic sig_is_boot(input logic [7:0] sig);
		return sig == `RBV_BOOT_SIG;
	endfunction

	// power-on and supply-monitor requests are the ones that pull the reset pin
	function automatic logic supply_reset(input logic [8:0] r);
		return r[`RBV_SRC_POR] | r[`RBV_SRC_SUPPLY];
	endfunction

	// every source seen during one reset stays marked until the next entry
	function automatic logic [8:0] merge_cause(input logic [8:0] old, input logic [8:0] r);
		return old | r;
	endfunction

	// gather the nine request levels; pin is active low
	always_comb begin
		raw_req = '0;
		raw_req[`RBV_SRC_POR]    = por_req;
		// our own pull on the pin reads back low; masked, or the block would hold itself forever
		raw_req[`RBV_SRC_PIN]    = !external_reset_pin_n_in & !st.drive_pin;
		raw_req[`RBV_SRC_CMP]    = cmp_req;
		raw_req[`RBV_SRC_SW]     = sw_req;
		raw_req[`RBV_SRC_SUPPLY] = supply_req;
		raw_req[`RBV_SRC_WDOG]   = wdog_req;
		raw_req[`RBV_SRC_MISCLK] = misclk_req;
		raw_req[`RBV_SRC_FLASH]  = flash_err_req;
		raw_req[`RBV_SRC_USB]    = usb_req;
	end

	// requests come from other domains and from the pin, so they are synchronised
	rbv_sync u_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.async_in (raw_req),
		.sync_out (req)
	);

	// sequencer: hold while any source asks, then count a short release.
	// a request shows here two edges after it rises (synchroniser), the hold
	// begins one edge later; once the last source lets go, the same three edges end the hold and
	// the core resumes release-count cycles after that; a source that returns mid-count restarts it
	always_comb begin
		next_st = st;
		next_st.pc_load = 1'b0;
		case (st.state)
			RBV_RUN: begin
				if (|req) begin
					next_st.state = RBV_HOLD;
					next_st.cause = req;
					next_st.drive_pin = supply_reset(req);
					next_st.por_seen = req[`RBV_SRC_POR];
					next_st.wdog_enable = 1'b0;
				end
			end
			RBV_HOLD: begin
				next_st.cause = merge_cause(st.cause, req);
				if (supply_reset(req)) begin
					next_st.drive_pin = 1'b1;
				end
				if (req[`RBV_SRC_POR]) begin
					next_st.por_seen = 1'b1;
				end
				next_st.rel_cnt = 3'(`RBV_REL_CYCLES);
				if (req == '0) begin
					next_st.state = RBV_RELEASE;
				end
			end
			RBV_RELEASE: begin
				if (|req) begin
					// a late request restarts the hold and is treated like any other
					next_st.state = RBV_HOLD;
					next_st.cause = merge_cause(st.cause, req);
					if (supply_reset(req)) begin
						next_st.drive_pin = 1'b1;
					end
					if (req[`RBV_SRC_POR]) begin
						next_st.por_seen = 1'b1;
					end
				end else if (st.rel_cnt <= 3'h1) begin
					// exit: vector chosen from signature sampled now
					next_st.state = RBV_RUN;
					next_st.drive_pin = 1'b0;
					next_st.por_seen = 1'b0;
					next_st.pc_load = 1'b1;
					next_st.boot_present = sig_is_boot(boot_sig_byte);
					next_st.pc_value = sig_is_boot(boot_sig_byte) ? boot_vector
						: `RBV_RESET_VECTOR;
					next_st.clk_select = `RBV_CLKSEL_RESET;
					next_st.wdog_enable = 1'b1;
				end else begin
					next_st.rel_cnt = st.rel_cnt - 3'h1;
				end
			end
			default: begin
				next_st.state = RBV_HOLD;
			end
		endcase
	end

	// synchronous reset leaves the block holding, as if power-on asked
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= '{state: RBV_HOLD, rel_cnt: 3'h0, drive_pin: 1'b1, por_seen: 1'b1,
				cause: 9'h001, pc_load: 1'b0, pc_value: `RBV_RESET_VECTOR, clk_select: `RBV_CLKSEL_RESET,
				wdog_enable: 1'b0, boot_present: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	logic in_reset;
	assign in_reset = st.state != RBV_RUN;

	// outputs to the core and peripherals
	assign core_halt         = in_reset;
	assign reg_reset         = in_reset;
	assign por_reg_reset     = in_reset & st.por_seen;
	assign irq_timer_disable = in_reset;
	assign ram_reset         = 1'b0;
	// pins float high through the pull-ups while latches are ones
	assign port_latch_set    = in_reset ? `RBV_PORT_RESET : 8'h00;
	assign port_open_drain   = in_reset ? `RBV_PORT_RESET : 8'h00;
	assign port_pullup_en    = `RBV_PORT_RESET;
	// open-drain: drive low only, enable high while pulling
	assign external_reset_pin_n_out = 1'b0;
	assign external_reset_pin_n_oe  = st.drive_pin & in_reset;
	assign pc_load           = st.pc_load;
	assign pc_value          = st.pc_value;
	assign clk_select        = st.clk_select;
	assign wdog_enable       = st.wdog_enable;
	assign boot_present      = st.boot_present;
	assign reset_cause       = st.cause;

	// halted with nothing asking: the release count runs
	sequence s_all_clear;
		core_halt && req == '0;
	endsequence

	sequence s_released;
		st.state == RBV_RUN;
	endsequence

	a_halt_in_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|req) |=> core_halt)
		else $error("core not halted after request");
	a_irq_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
		core_halt |-> irq_timer_disable)
		else $error("interrupts live during reset");
	a_ports_safe: assert property (@(posedge clk_sys) disable iff (!rst_n)
		core_halt |-> (port_latch_set == 8'hFF && port_open_drain == 8'hFF))
		else $error("ports not safe in reset");
	a_pullups_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		port_pullup_en == 8'hFF)
		else $error("pull-ups disabled");
	a_pin_supply: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(req[`RBV_SRC_POR] | req[`RBV_SRC_SUPPLY]) |=> external_reset_pin_n_oe)
		else $error("reset pin not driven for supply reset");
	a_pin_only_rst: assert property (@(posedge clk_sys) disable iff (!rst_n)
		external_reset_pin_n_oe |-> core_halt)
		else $error("reset pin driven outside reset");
	a_exit_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pc_load |-> (pc_value == (boot_present ? boot_vector : 16'h0000)))
		else $error("wrong start vector");
	a_exit_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pc_load |-> (wdog_enable && clk_select == 2'h0 && !core_halt))
		else $error("exit state wrong");
	a_release_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_all_clear [*4] |=> ##[0:2] s_released)
		else $error("release not reached");
	a_hold_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(core_halt && req != '0) |=> core_halt)
		else $error("released while requested");

	// a request from any source, and the halted state it must lead to
	sequence s_request;
		req != '0;
	endsequence

	sequence s_entered;
		core_halt && reg_reset && irq_timer_disable && !pc_load;
	endsequence

	// entry: everything that must be frozen one cycle after a request is seen
	a_entry_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_request |=> s_entered)
		else $error("core or timers live after request");
	a_wdog_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_request |=> !wdog_enable)
		else $error("watchdog left running in reset");
	a_no_exit_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_request |=> !pc_load)
		else $error("exit while a source asks");

	// power-on-only bits are cleared by power-on alone and kept on other resets
	a_por_bits_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req[`RBV_SRC_POR] |=> por_reg_reset)
		else $error("power-on bits not cleared");
	a_por_bits_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!core_halt && req != '0 && !req[`RBV_SRC_POR]) |=> !por_reg_reset)
		else $error("power-on bits cleared by other reset");

	// the pin pulls low only, never for other sources, and lets go on exit
	a_pin_low_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		external_reset_pin_n_oe |-> !external_reset_pin_n_out)
		else $error("reset pin driven high");
	a_pin_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!core_halt && req != '0 && !supply_reset(req)) |=> !external_reset_pin_n_oe)
		else $error("reset pin pulled for other source");
	a_pin_freed: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pc_load |-> !external_reset_pin_n_oe)
		else $error("reset pin held after exit");

	// the cause mask starts fresh on entry and gathers every later source
	a_cause_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!core_halt && req != '0) |=> (reset_cause == $past(req)))
		else $error("cause mask wrong on entry");
	a_cause_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(core_halt && req != '0) |=> ((reset_cause & $past(req)) == $past(req)))
		else $error("late source missing from cause");

	// exit: the vector follows the signature sampled on the exit edge
	a_sig_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pc_load |-> (boot_present == ($past(boot_sig_byte) == `RBV_BOOT_SIG)))
		else $error("signature decoded wrongly");
	a_vec_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pc_load |-> (pc_value == (($past(boot_sig_byte) == `RBV_BOOT_SIG) ? $past(boot_vector)
			: `RBV_RESET_VECTOR)))
		else $error("start vector does not follow signature");
	a_pc_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pc_load |=> !pc_load)
		else $error("program counter load not a pulse");
	a_exit_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pc_load |-> $past(core_halt))
		else $error("exit without a held reset");

	// while running with no request the exit settings stand untouched
	a_outputs_stand: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!core_halt && req == '0) |=> ($stable(wdog_enable) && $stable(clk_select) && $stable(pc_value)))
		else $error("exit settings changed while running");
endmodule

// [test/rbv_partner.sv]
// far side: reset button with pull-up on the shared pin, plus flash image
module rbv_partner #(
	parameter logic [15:0] boot_vec = 16'h3C00
) (
	input  wire logic        press,
	input  wire logic        pin_n_out,
	input  wire logic        pin_oe,
	input  wire logic        loader_on,
	output logic             pin_level,
	output logic [7:0]       sig_byte,
	output logic [15:0]      vector
);
	timeunit 1ns;
	timeprecision 1ps;
	// either party may pull low; the pull-up wins otherwise
	assign pin_level = ((pin_oe & ~pin_n_out) | press) ? 1'b0 : 1'b1;
	// a near-miss value stands for an erased signature
	assign sig_byte = loader_on ? 8'hA5 : 8'h5A;
	assign vector = boot_vec;
endmodule

// [test/test_reset_and_boot_vector_control.sv]
module test_reset_and_boot_vector_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] boot_vec = 16'h3C00;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [8:0]  req = 9'h000; // one bit per source, cause order
	logic        loader_on = 1'b0;
	logic        pin_level, core_halt, reg_reset, por_reg_reset, irq_dis, ram_reset;
	logic        pin_n_out, pin_oe, pc_load, wdog_enable, boot_present;
	logic [7:0]  latch_set, open_drain, pullup_en, sig_byte;
	logic [15:0] pc_value, vector;
	logic [1:0]  clk_select;
	logic [8:0]  reset_cause;
	int          mismatches = 0;
	int          samples_checked = 0;

	always #2 clk_sys = ~clk_sys;

	rbv_partner #(.boot_vec(boot_vec)) far (.press(req[1]), .pin_n_out(pin_n_out), .pin_oe(pin_oe),
		.loader_on(loader_on), .pin_level(pin_level), .sig_byte(sig_byte), .vector(vector));

	rbv_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .por_req(req[0]), .external_reset_pin_n_in(pin_level),
		.cmp_req(req[2]), .sw_req(req[3]), .supply_req(req[4]), .wdog_req(req[5]), .misclk_req(req[6]),
		.flash_err_req(req[7]), .usb_req(req[8]), .boot_sig_byte(sig_byte), .boot_vector(vector),
		.core_halt(core_halt), .reg_reset(reg_reset), .por_reg_reset(por_reg_reset),
		.irq_timer_disable(irq_dis), .ram_reset(ram_reset), .port_latch_set(latch_set),
		.port_open_drain(open_drain), .port_pullup_en(pullup_en), .external_reset_pin_n_out(pin_n_out),
		.external_reset_pin_n_oe(pin_oe), .pc_load(pc_load), .pc_value(pc_value),
		.clk_select(clk_select), .wdog_enable(wdog_enable), .boot_present(boot_present),
		.reset_cause(reset_cause));

	task check(input logic [15:0] seen, input logic [15:0] expected);
		samples_checked++;
		if (seen !== expected) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expected);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// bounded wait for the exit pulse, then the state the core resumes in
	task exit_state(input logic boot);
		int n;
		n = 0;
		while (pc_load !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		// two synchroniser edges, one to leave the hold, four to count out
		check(16'(n), 16'h0007);
		check(pin_oe, 1'h0);
		check(core_halt, 1'h0);
		check(pc_value, boot ? boot_vec : 16'h0000);
		check(clk_select, 2'h0);
		check(wdog_enable, 1'h1);
		check(boot_present, boot);
		check(pullup_en, 16'h00FF);
		check(ram_reset, 1'h0);
		@(negedge clk_sys);
		check(pc_load, 1'h0);
	endtask

	// one source at a time, every source, signature toggled between runs
	task one_source(input int s, input logic boot);
		loader_on = boot;
		req[s] = 1'b1;
		repeat (5) @(negedge clk_sys);
		check(core_halt, 1'h1);
		check(reg_reset, 1'h1);
		check(por_reg_reset, s == 0);
		check(irq_dis, 1'h1);
		check(latch_set, 16'h00FF);
		check(open_drain, 16'h00FF);
		check(pullup_en, 16'h00FF);
		check(pin_oe, s == 0 || s == 4);
		check(pin_level, s != 0 && s != 4 && s != 1);
		check(pin_n_out, 1'h0);
		check(wdog_enable, 1'h0);
		check(ram_reset, 1'h0);
		req[s] = 1'b0;
		exit_state(boot);
		check(reset_cause[s], 1'h1);
	endtask

	// overlapping requests: release waits for the last one to clear
	task overlap;
		loader_on = 1'b1;
		req[2] = 1'b1;
		req[5] = 1'b1;
		repeat (5) @(negedge clk_sys);
		req[2] = 1'b0;
		repeat (12) @(negedge clk_sys);
		check(core_halt, 1'h1);
		req[5] = 1'b0;
		exit_state(1'b1);
		check({reset_cause[5], reset_cause[2]}, 2'h3);
	endtask

	initial begin
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		exit_state(1'b0);
		for (int s = 0; s < 9; s++) one_source(s, s[0]);
		overlap();
		results();
	end

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#20000;
		mismatches++;
		results();
	end
endmodule
